/* File: hdl/dpp_pkg.sv */
// Purpose: Constants, types and address decode for the daisy-chain pot port
// Assumes: 16-bit shift stage, 8-bit registers
// Notes:   Shared by the port and its command FIFO
package dpp_pkg;

	// Shift stage and command FIFO shape
	localparam int DPP_SHIFT_W     = 16;
	localparam int DPP_FIFO_DEPTH  = 8;
	localparam int DPP_FIFO_AW     = 3;

	// Instruction word fields
	localparam int DPP_OP_MSB      = 15;
	localparam int DPP_OP_LSB      = 13;
	localparam int DPP_ADDR_MSB    = 12;
	localparam int DPP_ADDR_LSB    = 8;
	localparam int DPP_DATA_MSB    = 7;

	// Register addresses
	localparam logic [4:0] DPP_ADDR_WIPER_A = 5'h00;
	localparam logic [4:0] DPP_ADDR_WIPER_B = 5'h01;
	localparam logic [4:0] DPP_ADDR_ACCESS  = 5'h10;

	// Operation codes
	localparam logic [2:0] DPP_OP_NOP      = 3'h0;
	localparam logic [2:0] DPP_OP_ACC_RD   = 3'h1;
	localparam logic [2:0] DPP_OP_ACC_WR   = 3'h3;
	localparam logic [2:0] DPP_OP_RD       = 3'h4;
	localparam logic [2:0] DPP_OP_WR       = 3'h6;
	localparam logic [2:0] DPP_RESP_CODE   = 3'h7;

	// Reset values and access control fields
	localparam logic [7:0] DPP_WIPER_RST   = 8'h80;
	localparam logic [7:0] DPP_ACCESS_RST  = 8'h40;
	localparam logic [7:0] DPP_ACCESS_WMSK = 8'h42;
	localparam int         DPP_ACC_SHDN_N  = 6;
	localparam int         DPP_ACC_ODRAIN  = 1;

	// One-hot register select
	localparam logic [2:0] DPP_SEL_NONE    = 3'b000;
	localparam logic [2:0] DPP_SEL_A       = 3'b001;
	localparam logic [2:0] DPP_SEL_B       = 3'b010;
	localparam logic [2:0] DPP_SEL_ACC     = 3'b100;

	typedef enum logic [1:0] {
		DPP_ST_IDLE  = 2'b01,
		DPP_ST_FRAME = 2'b10
	} dpp_state_t;

	// Address to register select
	function automatic logic [2:0] dpp_sel(input logic [4:0] addr);
		logic [2:0] sel;
		sel = DPP_SEL_NONE;
		if (addr == DPP_ADDR_WIPER_A)
			sel = DPP_SEL_A;
		else if (addr == DPP_ADDR_WIPER_B)
			sel = DPP_SEL_B;
		else if (addr == DPP_ADDR_ACCESS)
			sel = DPP_SEL_ACC;
		return sel;
	endfunction : dpp_sel

endpackage : dpp_pkg

/* File: hdl/dpp_fifo_if.sv */
// Purpose: Valid/ready carrier between the port and its command FIFO
// Assumes: Single clock domain
// Notes:   push side fills, pop side drains
`timescale 1ns/10ps
interface dpp_fifo_if #(parameter int WIDTH = 16);
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] push_data;
	logic             pop_valid;
	logic             pop_ready;
	logic [WIDTH-1:0] pop_data;

	modport user (output push_valid, push_data, pop_ready,
	              input  push_ready, pop_valid, pop_data);
	modport fifo (input  push_valid, push_data, pop_ready,
	              output push_ready, pop_valid, pop_data);
endinterface : dpp_fifo_if

/* File: hdl/dpp_fifo.sv */
// Purpose: Command FIFO of flip-flops with valid/ready on both sides
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes:   Full drops push_ready, empty drops pop_valid
`timescale 1ns/10ps
module dpp_fifo
	import dpp_pkg::*;
#(
	parameter int WIDTH = DPP_SHIFT_W,
	parameter int DEPTH = DPP_FIFO_DEPTH,
	parameter int AW    = DPP_FIFO_AW
)
(
	// Clock and reset
	input  wire logic  mclk,
	input  wire logic  rst,
	// Both sides
	dpp_fifo_if.fifo   q
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_push;
	logic             do_pop;

	assign q.push_ready = (count != (AW+1)'(DEPTH));
	assign q.pop_valid  = (count != '0);
	assign q.pop_data   = mem[rd_ptr];
	assign do_push      = q.push_valid & q.push_ready;
	assign do_pop       = q.pop_valid & q.pop_ready;

	always_comb
	begin
		next_wr_ptr = do_push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = do_pop ? rd_ptr + AW'(1) : rd_ptr;
		next_count  = count;
		if (do_push & ~do_pop)
			next_count = count + (AW+1)'(1);
		else if (do_pop & ~do_push)
			next_count = count - (AW+1)'(1);
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage has no reset; only written slots are read
	always_ff @(posedge mclk)
	begin
		if (do_push)
			mem[wr_ptr] <= q.push_data;
	end

endmodule : dpp_fifo

/* File: hdl/dpp_port.sv */
// Purpose: Serial slave port of a dual digital pot with daisy chaining
// Assumes: mclk well above the serial clock; pins are asynchronous
// Notes:   Commands latched at frame end pass through an 8-word FIFO
`timescale 1ns/10ps
module dpp_port
	import dpp_pkg::*;
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Serial pins
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic       sdi,
	output logic            sdo,
	output logic            sdo_oe,
	// Register contents
	output logic [7:0]      wiper_position_a,
	output logic [7:0]      wiper_position_b,
	output logic [7:0]      access_control
);

	// Pin synchronisers
	logic [1:0]             cs_n_sync;
	logic [1:0]             sck_sync;
	logic [1:0]             sdi_sync;
	logic                   cs_s;
	logic                   sck_s;
	logic                   sdi_s;
	logic                   sck_d;
	logic                   sck_rise;
	logic                   sck_fall;
	logic [1:0]             next_cs_n_sync;
	logic [1:0]             next_sck_sync;
	logic [1:0]             next_sdi_sync;
	logic                   next_sck_d;

	// Shift stage
	dpp_state_t             state;
	dpp_state_t             next_state;
	logic [DPP_SHIFT_W-1:0] shreg;
	logic [DPP_SHIFT_W-1:0] next_shreg;
	logic                   sdo_q;
	logic                   next_sdo_q;
	logic                   frame_start;
	logic                   frame_end;

	// Command hand-off
	logic                   cmd_valid;
	logic                   next_cmd_valid;
	logic [DPP_SHIFT_W-1:0] cmd_word;
	logic [DPP_SHIFT_W-1:0] next_cmd_word;

	// Register file and read answer
	logic [7:0]             next_wiper_a;
	logic [7:0]             next_wiper_b;
	logic [7:0]             next_access;
	logic [DPP_SHIFT_W-1:0] resp;
	logic [DPP_SHIFT_W-1:0] next_resp;
	logic                   resp_valid;
	logic                   next_resp_valid;

	// Decoded command
	logic                   exec;
	logic [2:0]             op;
	logic [4:0]             addr;
	logic [4:0]             eff_addr;
	logic [7:0]             wdata;
	logic [2:0]             sel;
	logic [7:0]             rdata;

	dpp_fifo_if #(.WIDTH(DPP_SHIFT_W)) cmdq ();

	dpp_fifo #(
		.WIDTH (DPP_SHIFT_W),
		.DEPTH (DPP_FIFO_DEPTH),
		.AW    (DPP_FIFO_AW)
	) u_cmd_fifo (
		.mclk (mclk),
		.rst  (rst),
		.q    (cmdq)
	);

	// Pins step into their synchronisers
	always_comb
	begin
		next_cs_n_sync = {cs_n_sync[0], cs_n};
		next_sck_sync  = {sck_sync[0], sck};
		next_sdi_sync  = {sdi_sync[0], sdi};
		next_sck_d     = sck_sync[1];
	end

	// Two flops on every pin
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cs_n_sync <= 2'h3;
			sck_sync  <= 2'h0;
			sdi_sync  <= 2'h0;
			sck_d     <= 1'b0;
		end
		else
		begin
			cs_n_sync <= next_cs_n_sync;
			sck_sync  <= next_sck_sync;
			sdi_sync  <= next_sdi_sync;
			sck_d     <= next_sck_d;
		end
	end

	assign cs_s  = cs_n_sync[1];
	assign sck_s = sck_sync[1];
	assign sdi_s = sdi_sync[1];

	assign sck_rise = sck_s & ~sck_d;
	assign sck_fall = ~sck_s & sck_d;

	assign frame_start = (state == DPP_ST_IDLE) & ~cs_s;
	assign frame_end   = (state == DPP_ST_FRAME) & cs_s;

	always_comb
	begin
		next_state = state;
		next_shreg = shreg;
		next_sdo_q = sdo_q;
		case (state)
			DPP_ST_IDLE:
			begin
				if (~cs_s)
				begin
					next_state = DPP_ST_FRAME;
					next_shreg = resp_valid ? resp : '0;
					next_sdo_q = resp_valid ? resp[DPP_SHIFT_W-1] : 1'b0;
				end
			end
			DPP_ST_FRAME:
			begin
				if (cs_s)
					next_state = DPP_ST_IDLE;
				else
				begin
					if (sck_rise)
						next_shreg = {shreg[DPP_SHIFT_W-2:0], sdi_s};
					if (sck_fall)
						next_sdo_q = shreg[DPP_SHIFT_W-1];
				end
			end
			default:
			begin
				next_state = DPP_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state <= DPP_ST_IDLE;
			shreg <= '0;
			sdo_q <= 1'b0;
		end
		else
		begin
			state <= next_state;
			shreg <= next_shreg;
			sdo_q <= next_sdo_q;
		end
	end

	assign sdo = sdo_q;
	assign sdo_oe = (state == DPP_ST_FRAME) & (~access_control[DPP_ACC_ODRAIN] | ~sdo_q);

	// capture held word at select rise
	always_comb
	begin
		next_cmd_valid = cmd_valid & ~cmdq.push_ready;
		next_cmd_word  = cmd_word;
		if (frame_end)
		begin
			next_cmd_valid = 1'b1;
			next_cmd_word  = shreg;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			cmd_valid <= 1'b0;
			cmd_word  <= '0;
		end
		else
		begin
			cmd_valid <= next_cmd_valid;
			cmd_word  <= next_cmd_word;
		end
	end

	assign cmdq.push_valid = cmd_valid;
	assign cmdq.push_data  = cmd_word;
	// Drain only between frames
	assign cmdq.pop_ready  = (state == DPP_ST_IDLE) & cs_s;

	assign exec  = cmdq.pop_valid & cmdq.pop_ready;
	assign op    = cmdq.pop_data[DPP_OP_MSB:DPP_OP_LSB];
	assign addr  = cmdq.pop_data[DPP_ADDR_MSB:DPP_ADDR_LSB];
	assign wdata = cmdq.pop_data[DPP_DATA_MSB:0];

	assign eff_addr = ((op == DPP_OP_ACC_RD) | (op == DPP_OP_ACC_WR)) ? DPP_ADDR_ACCESS : addr;
	assign sel = dpp_sel(eff_addr);

	always_comb
	begin
		case (sel)
			DPP_SEL_A:   rdata = wiper_position_a;
			DPP_SEL_B:   rdata = wiper_position_b;
			DPP_SEL_ACC: rdata = access_control;
			default:     rdata = 8'h00;
		endcase
	end

	always_comb
	begin
		next_wiper_a    = wiper_position_a;
		next_wiper_b    = wiper_position_b;
		next_access     = access_control;
		next_resp       = resp;
		next_resp_valid = resp_valid & ~frame_start;
		if (exec)
		begin
			case (op)
				DPP_OP_WR, DPP_OP_ACC_WR:
				begin
					if (sel == DPP_SEL_A)
						next_wiper_a = wdata;
					if (sel == DPP_SEL_B)
						next_wiper_b = wdata;
					if (sel == DPP_SEL_ACC)
						next_access = wdata & DPP_ACCESS_WMSK;
				end
				DPP_OP_RD, DPP_OP_ACC_RD:
				begin
					next_resp       = {DPP_RESP_CODE, eff_addr, rdata};
					next_resp_valid = 1'b1;
				end
				default:
				begin
					next_resp_valid = resp_valid & ~frame_start;
				end
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			wiper_position_a <= DPP_WIPER_RST;
			wiper_position_b <= DPP_WIPER_RST;
			access_control   <= DPP_ACCESS_RST;
			resp             <= '0;
			resp_valid       <= 1'b0;
		end
		else
		begin
			wiper_position_a <= next_wiper_a;
			wiper_position_b <= next_wiper_b;
			access_control   <= next_access;
			resp             <= next_resp;
			resp_valid       <= next_resp_valid;
		end
	end

endmodule : dpp_port

/* File: bench/dpp_port_properties.sv */
// Purpose: Assertions on the pins and registers of dpp_port
// Assumes: Push-pull output unless access_control[1] is set
// Notes:   Bound to every dpp_port instance
`timescale 1ns/10ps
module dpp_port_properties
	import dpp_pkg::*;
(
	// Clock and reset
	input wire logic       mclk,
	input wire logic       rst,
	// Serial pins
	input wire logic       cs_n,
	input wire logic       sck,
	input wire logic       sdi,
	input wire logic       sdo,
	input wire logic       sdo_oe,
	// Registers
	input wire logic [7:0] wiper_position_a,
	input wire logic [7:0] wiper_position_b,
	input wire logic [7:0] access_control
);
	logic [3:0] hi_cnt;
	logic [3:0] next_hi_cnt;

	// Cycles since deselect
	always_comb
	begin
		next_hi_cnt = cs_n ? hi_cnt : 4'h0;
		if (cs_n && hi_cnt != 4'hf)
			next_hi_cnt = hi_cnt + 4'h1;
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			hi_cnt <= 4'hf;
		else
			hi_cnt <= next_hi_cnt;
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_idle;
		cs_n[*6];
	endsequence
	sequence s_busy;
		!cs_n[*6];
	endsequence

	a_oe_idle_off:
		assert property (s_idle |-> !sdo_oe) else $error("sdo driven while idle");
	a_oe_frame_on:
		assert property (s_busy |-> sdo_oe || access_control[1]) else $error("sdo not driven");
	a_oe_release:
		assert property ($rose(cs_n) |-> ##[1:5] !sdo_oe) else $error("sdo not released");
	a_sdo_hold_high:
		assert property ((!cs_n && sck)[*3] |-> $stable(sdo)) else $error("sdo moved");
	a_wipa_at_end:
		assert property ($changed(wiper_position_a) |-> hi_cnt != 4'h0 && hi_cnt != 4'hf)
			else $error("wiper a changed off frame end");
	a_wipb_at_end:
		assert property ($changed(wiper_position_b) |-> hi_cnt != 4'h0 && hi_cnt != 4'hf)
			else $error("wiper b changed off frame end");
	a_acc_at_end:
		assert property ($changed(access_control) |-> hi_cnt != 4'h0 && hi_cnt != 4'hf)
			else $error("control changed off frame end");
	a_acc_fixed_bits:
		assert property ((access_control & 8'hbd) == 8'h00) else $error("fixed bits set");
endmodule : dpp_port_properties

bind dpp_port dpp_port_properties dpp_port_properties_i (
	.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo(sdo),
	.sdo_oe(sdo_oe), .wiper_position_a(wiper_position_a),
	.wiper_position_b(wiper_position_b), .access_control(access_control));

/* File: bench/dpp_host.sv */
// Purpose: Host model driving mode 0 frames
// Assumes: Serial clock of 8 mclk, 5 low and 3 high
// Notes:   sdi shows the inverse of its last bit when idle
`timescale 1ns/10ps
module dpp_host
(
	// Clock
	input wire logic mclk,
	// Serial pins
	output logic     cs_n,
	output logic     sck,
	output logic     sdi,
	input wire logic sdo_line
);
	initial
	begin
		cs_n = 1'b1;
		sck  = 1'b0;
		sdi  = 1'b0;
	end

	task automatic frame(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
		rx = 32'h0;
		cs_n <= 1'b0;
		repeat (4) @(posedge mclk);
		for (int i = nbits - 1; i >= 0; i--)
		begin
			sdi <= tx[i];
			repeat (5) @(posedge mclk);
			sck <= 1'b1;
			rx = {rx[30:0], sdo_line};
			repeat (3) @(posedge mclk);
			sck <= 1'b0;
		end
		repeat (4) @(posedge mclk);
		cs_n <= 1'b1;
		sdi  <= ~sdi;
		repeat (12) @(posedge mclk);
	endtask : frame
endmodule : dpp_host

/* File: bench/dpp_port_bench.sv */
// Purpose: Self-checking bench for dpp_port
// Assumes: One device; pull-up on sdo only in open-drain mode
// Notes:   Host model drives the pins
`timescale 1ns/10ps
module dpp_port_bench
	import dpp_pkg::*;
;
	logic        mclk = 1'b0;
	logic        rst  = 1'b1;
	logic        cs_n;
	logic        sck;
	logic        sdi;
	logic        sdo;
	logic        sdo_oe;
	wire         sdo_line;
	logic [7:0]  wiper_position_a;
	logic [7:0]  wiper_position_b;
	logic [7:0]  access_control;
	logic [31:0] rx;
	logic [2:0]  bad [3] = '{3'h2, 3'h5, 3'h7};
	int          fails    = 0;
	int          compares = 0;

	always #10 mclk = ~mclk;
	// Released line: pulled up in open-drain mode, else shows the inverse
	assign sdo_line = sdo_oe ? sdo : (access_control[DPP_ACC_ODRAIN] ? 1'b1 : ~sdo);

	dpp_host dpp_host_i (.mclk(mclk), .cs_n(cs_n), .sck(sck), .sdi(sdi), .sdo_line(sdo_line));
	dpp_port dpp_port_i (.mclk(mclk), .rst(rst), .cs_n(cs_n), .sck(sck), .sdi(sdi),
		.sdo(sdo), .sdo_oe(sdo_oe), .wiper_position_a(wiper_position_a),
		.wiper_position_b(wiper_position_b), .access_control(access_control));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask : check

	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic cmd(input logic [2:0] op, input logic [4:0] addr, input logic [7:0] data);
		dpp_host_i.frame({16'h0, op, addr, data}, 16, rx);
	endtask : cmd

	// Read instruction, then no-op frame carrying the answer
	task automatic rd(input logic [2:0] op, input logic [4:0] addr, input logic [7:0] exp);
		cmd(op, addr, 8'h00);
		dpp_host_i.frame(32'h0, 16, rx);
		check("answer", rx, {16'h0, DPP_RESP_CODE, addr, exp});
	endtask : rd

	task automatic regs(input logic [23:0] exp);
		check("registers", {8'h0, wiper_position_a, wiper_position_b, access_control},
			{8'h0, exp});
	endtask : regs

	initial
	begin
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		regs(24'h808040);
		rd(DPP_OP_RD, DPP_ADDR_WIPER_A, 8'h80);
		rd(DPP_OP_RD, DPP_ADDR_ACCESS, 8'h40);
		$display("Test reset values done");
		dpp_host_i.frame(32'h1234_c055, 32, rx);
		check("pass-through", rx, 32'h0000_1234);
		regs(24'h558040);
		cmd(DPP_OP_WR, DPP_ADDR_WIPER_B, 8'ha5);
		rd(DPP_OP_RD, DPP_ADDR_WIPER_B, 8'ha5);
		$display("Test chain and wipers done");
		cmd(DPP_OP_ACC_WR, 5'h07, 8'hff);
		rd(DPP_OP_ACC_RD, DPP_ADDR_ACCESS, 8'h42);
		cmd(DPP_OP_WR, DPP_ADDR_ACCESS, 8'hbd);
		regs(24'h55a500);
		cmd(DPP_OP_ACC_WR, 5'h00, 8'h40);
		foreach (bad[i])
			cmd(bad[i], 5'h00, 8'h11);
		cmd(DPP_OP_WR, 5'h02, 8'h33);
		cmd(DPP_OP_NOP, 5'h00, 8'h77);
		regs(24'h55a540);
		check("sdo_oe", {31'h0, sdo_oe}, 32'h0);
		$display("Test control and refusals done");
		end_sim();
	end

	initial
	begin
		#200000;
		fails++;
		end_sim();
	end
endmodule : dpp_port_bench
